// ==== include/lvm_pkg.sv ====
// shared constants and types for the low-voltage reset monitor
// assumes one 100 MHz clock domain and an 8-bit register port
package lvm_pkg;
   // register port widths and offsets
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] EVENT_OFS = 8'h01;
   localparam logic [7:0] CONFIG_OFS = 8'h02;
   // field positions
   localparam int FLAG_BIT = 0;
   localparam int EVT_RESET_BIT = 0;
   localparam int EVT_STOP_BIT = 1;
   localparam int CFG_POWER_BIT = 0;
   localparam int CFG_RESETEN_BIT = 1;
   localparam int CFG_STOPEN_BIT = 2;
   localparam int CFG_HOLD_BIT = 7;
   // reset values
   localparam logic [1:0] EVENT_RST = 2'h0;
   localparam logic [7:0] RDATA_RST = 8'h00;
   // timing counts
   localparam int FILTER_CYCLES = 9;
   localparam int FLAG_MIN_OSC = 32;
   localparam int FLAG_MAX_OSC = 40;
   localparam int FLAG_SET_OSC = 36;
   localparam int FILT_CNT_W = 4;
   localparam int OSC_CNT_W = 6;

   typedef struct packed {
      logic stopEn;
      logic resetEn;
      logic power;
   } lvm_opts_t;

   typedef enum logic [1:0] {
      PH_WATCH = 2'b01,
      PH_HOLD = 2'b10
   } lvm_phase_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } lvm_bus_t;

   typedef struct packed {
      lvm_opts_t opts;
      logic optsValid;
      logic xtalPrev;
      logic [FILT_CNT_W-1:0] filtCnt;
      lvm_phase_t phase;
      logic lvReset;
      logic pinOut;
      logic pinDrvN;
      logic wakeReq;
      logic [1:0] events;
      logic [DATA_W-1:0] rdata;
   } lvm_main_t;

   typedef struct packed {
      logic [OSC_CNT_W-1:0] cnt;
      logic flag;
   } lvm_timer_t;
endpackage

// ==== rtl/lvm_sync.sv ====
// two-stage synchroniser for asynchronous levels
// assumes inputs are levels from outside the mclk domain
`timescale 1ns/1ps
module lvm_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // levels
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } lvm_sync_t;

   lvm_sync_t q;
   lvm_sync_t d;

   // first stage feeds only the second
   always_comb begin
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule

// ==== rtl/lvm_flag_timer.sv ====
// low-supply status flag timed in crystal oscillator ticks
// assumes tick is a one-cycle pulse per oscillator cycle, inputs synchronous
`timescale 1ns/1ps
module lvm_flag_timer (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // oscillator tick and comparator levels
   input wire logic tick,
   input wire logic below,
   input wire logic above,
   // control
   input wire logic enable,
   input wire logic clear,
   // status
   output logic flag
);
   import lvm_pkg::*;

   localparam logic [OSC_CNT_W-1:0] SET_CNT = OSC_CNT_W'(FLAG_SET_OSC);

   lvm_timer_t q;
   lvm_timer_t d;

   // count ticks while low, hold between trip levels
   always_comb begin
      d = q;
      if (clear) begin
         d.cnt = '0; // [R9]
         d.flag = 1'b0;
      end else if (!enable) begin
         d.cnt = '0;
      end else if (above) begin
         d.cnt = '0; // [R8]
         d.flag = 1'b0;
      end else if (below) begin
         if (q.cnt == SET_CNT) begin
            d.flag = 1'b1; // [R7]
         end else if (tick) begin
            d.cnt = q.cnt + 1'b1;
         end
      end else begin
         d.cnt = '0; // [R8]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign flag = q.flag;

   flag_clear_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
      clear |=> !flag) else $error("flag not cleared by reset");
   above_zero_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
      enable && above && !clear |=> !flag) else $error("flag set above rising level");
   flag_set_a: assert property (@(posedge mclk) disable iff (rst) // [R7]
      $rose(flag) |-> $past(q.cnt) == SET_CNT) else $error("flag set at wrong count");
endmodule

// ==== rtl/lvm_monitor.sv ====
// low-voltage reset monitor: filter, status flag, forced reset
// assumes comparator outputs and oscillator pin are asynchronous,
// power modes and other reset sources come from mclk logic
//
// Contract
// R1: monitoring starts straight out of reset without software help.
// R2: comparator is ignored while the monitor power option is clear.
// R3: nine consecutive low CPU cycles with reset enable force a reset.
// R4: reset holds until the supply is above the rising level.
// R5: one cycle above the rising level releases the reset.
// R6: the reset also pulls the external reset pin low.
// R7: status flag sets after 32 to 40 low oscillator cycles.
// R8: flag clears above rising level, holds between the levels.
// R9: any system reset clears the status flag.
// R10: power set, reset enable clear means flag only, never reset.
// R11: the three options are fixed straps, not software writable.
// R12: the block never raises an interrupt request.
// R13: monitor keeps running in wait mode when powered.
// R14: a reset during wait mode wakes the processor.
// R15: stop mode with stop option trips directly, bypassing the filter.
// R16: stop mode without stop option leaves the monitor idle.
// R17: flag timing uses the crystal oscillator clock.
// R18: any cycle not low restarts the filter count from zero.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module lvm_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // factory option straps
   input wire logic monitorPowerOption,
   input wire logic lowSupplyResetEnable,
   input wire logic stopModeMonitorEnable,
   // analog comparator outputs
   input wire logic supplyBelowFall,
   input wire logic supplyAboveRise,
   // crystal oscillator clock pin
   input wire logic crystalOscillatorClock,
   // processor power modes
   input wire logic waitMode,
   input wire logic stopMode,
   // other system reset sources
   input wire logic sysResetIn,
   // register port
   input wire lvm_pkg::lvm_bus_t regBus,
   output logic [lvm_pkg::DATA_W-1:0] regRdata,
   // reset and wake outputs
   output logic lowSupplyReset,
   output logic resetPinOut,
   output logic resetPinOeN,
   output logic wakeRequest,
   // status
   output logic lowSupplyFlag
);
   import lvm_pkg::*;

   localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(FILTER_CYCLES - 1);

   localparam lvm_main_t MAIN_RST = '{
      opts: '0,
      optsValid: 1'b0,
      xtalPrev: 1'b0,
      filtCnt: '0,
      phase: PH_WATCH,
      lvReset: 1'b0,
      pinOut: 1'b0,
      pinDrvN: 1'b1,
      wakeReq: 1'b0,
      events: EVENT_RST,
      rdata: RDATA_RST
   };

   lvm_main_t q;
   lvm_main_t d;
   logic [2:0] syncOut;
   logic xtalS;
   logic belowS;
   logic aboveS;
   logic xtalTick;
   logic active;
   logic armed;
   logic stopTrip;
   logic timerClear;
   logic flagQ;

   // comparator and oscillator levels cross into mclk
   lvm_sync #(
      .WIDTH(3)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .din({crystalOscillatorClock, supplyAboveRise, supplyBelowFall}),
      .dout(syncOut)
   );

   assign belowS = syncOut[0];
   assign aboveS = syncOut[1];
   assign xtalS = syncOut[2];

   // one pulse per crystal oscillator cycle
   assign xtalTick = xtalS & ~q.xtalPrev; // [R17]

   // powered, and not parked in stop without the stop option
   assign active = q.opts.power && !(stopMode && !q.opts.stopEn); // [R2] [R13] [R16]

   // filtered path runs on CPU cycles only, so never in stop
   assign armed = active && q.opts.resetEn && belowS && !stopMode; // [R3] [R10]

   // stop mode has no CPU clock, so the trip goes straight through
   assign stopTrip = stopMode && q.opts.power && q.opts.stopEn
                     && q.opts.resetEn && belowS; // [R15]

   // any system reset, ours included, clears the flag
   assign timerClear = sysResetIn || q.lvReset; // [R9]

   // status flag timed on the crystal oscillator ticks
   lvm_flag_timer u_flag (
      .mclk(mclk),
      .rst(rst),
      .tick(xtalTick),
      .below(belowS),
      .above(aboveS),
      .enable(active),
      .clear(timerClear),
      .flag(flagQ)
   );

   // next-state logic for straps, filter, reset phase and registers
   always_comb begin
      d = q;
      d.wakeReq = 1'b0;
      d.xtalPrev = xtalS;
      d.rdata = RDATA_RST;

      // straps caught once after reset release, then frozen
      if (!q.optsValid) begin
         d.opts.power = monitorPowerOption; // [R11] [R1]
         d.opts.resetEn = lowSupplyResetEnable;
         d.opts.stopEn = stopModeMonitorEnable;
         d.optsValid = 1'b1;
      end

      // write-one-to-clear of the event bits, sets below win
      if (regBus.wr && regBus.addr == EVENT_OFS) begin
         d.events = q.events & ~regBus.wdata[1:0];
      end

      // reset phase sequencing
      unique case (q.phase)
         PH_WATCH: begin
            if (stopTrip || (armed && q.filtCnt == FILT_LAST)) begin
               d.phase = PH_HOLD; // [R3] [R15]
               d.filtCnt = '0;
               d.wakeReq = waitMode || stopMode; // [R14]
               d.events[EVT_RESET_BIT] = 1'b1;
               if (stopTrip) begin
                  d.events[EVT_STOP_BIT] = 1'b1;
               end
            end else if (armed) begin
               d.filtCnt = q.filtCnt + 1'b1; // [R3]
            end else begin
               d.filtCnt = '0; // [R18]
            end
         end
         PH_HOLD: begin
            d.filtCnt = '0;
            if (aboveS) begin
               d.phase = PH_WATCH; // [R5]
            end else begin
               d.phase = PH_HOLD; // [R4]
            end
         end
      endcase

      // reset output and open-drain pin follow the phase
      d.lvReset = (d.phase == PH_HOLD);
      d.pinOut = 1'b0;
      d.pinDrvN = (d.phase != PH_HOLD); // [R6]

      // register reads, answered next cycle
      if (regBus.rd) begin
         unique case (regBus.addr)
            STATUS_OFS: begin
               d.rdata[FLAG_BIT] = flagQ;
            end
            EVENT_OFS: begin
               d.rdata[1:0] = q.events;
            end
            CONFIG_OFS: begin
               d.rdata[CFG_POWER_BIT] = q.opts.power;
               d.rdata[CFG_RESETEN_BIT] = q.opts.resetEn;
               d.rdata[CFG_STOPEN_BIT] = q.opts.stopEn;
               d.rdata[CFG_HOLD_BIT] = (q.phase == PH_HOLD);
            end
            default: begin
               d.rdata = RDATA_RST;
            end
         endcase
      end
   end

   // single state register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= MAIN_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops; reset and wake only, no interrupt [R12]
   assign lowSupplyReset = q.lvReset;
   assign resetPinOut = q.pinOut;
   assign resetPinOeN = q.pinDrvN;
   assign wakeRequest = q.wakeReq;
   assign regRdata = q.rdata;
   assign lowSupplyFlag = flagQ;

   // assertion helpers: unbroken armed run and low oscillator ticks
   logic [FILT_CNT_W-1:0] armRun;
   logic [OSC_CNT_W-1:0] lowTicks;

   // length of the current armed run, held at the trip count
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         armRun <= '0;
      end else if (!armed) begin
         armRun <= '0;
      end else if (armRun != FILT_LAST) begin
         armRun <= armRun + 1'b1;
      end
   end

   // oscillator ticks in the current unbroken low stretch, saturating
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lowTicks <= '0;
      end else if (timerClear || !active || aboveS || !belowS) begin
         lowTicks <= '0;
      end else if (xtalTick && lowTicks != '1) begin
         lowTicks <= lowTicks + 1'b1;
      end
   end

   // filter trip after nine unbroken low cycles
   filter_trip_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
      armed && armRun == FILT_LAST |=> lowSupplyReset)
      else $error("no reset after nine low cycles");

   // nothing but a low cycle or stop trip may start a reset
   no_early_a: assert property (@(posedge mclk) disable iff (rst) // [R18]
      !lowSupplyReset && !stopTrip && q.filtCnt != FILT_LAST |=> !lowSupplyReset)
      else $error("reset before filter completed");

   // count restarts when a cycle is not low
   filt_restart_a: assert property (@(posedge mclk) disable iff (rst) // [R18]
      !armed |=> q.filtCnt == '0)
      else $error("filter count not restarted");

   // reset held while supply not above rising level
   hold_keep_a: assert property (@(posedge mclk) disable iff (rst) // [R4]
      lowSupplyReset && !aboveS |=> lowSupplyReset)
      else $error("reset released too early");

   // one cycle above rising level releases
   hold_release_a: assert property (@(posedge mclk) disable iff (rst) // [R5]
      lowSupplyReset && aboveS |=> !lowSupplyReset)
      else $error("reset not released");

   // pin driven low exactly while in reset
   pin_drive_a: assert property (@(posedge mclk) disable iff (rst) // [R6]
      resetPinOeN == !lowSupplyReset && !resetPinOut)
      else $error("reset pin does not follow reset");

   // polled mode never resets
   poll_only_a: assert property (@(posedge mclk) disable iff (rst) // [R10]
      !q.opts.resetEn |-> !lowSupplyReset)
      else $error("reset with reset enable clear");

   // unpowered monitor ignores the comparator
   power_off_a: assert property (@(posedge mclk) disable iff (rst) // [R2]
      !q.opts.power && !lowSupplyReset |=> !lowSupplyReset)
      else $error("reset with monitor unpowered");

   // straps frozen once caught
   strap_hold_a: assert property (@(posedge mclk) disable iff (rst) // [R11]
      q.optsValid |=> $stable(q.opts))
      else $error("options changed at run time");

   // reset from wait mode wakes the processor
   wake_pulse_a: assert property (@(posedge mclk) disable iff (rst) // [R14]
      $rose(lowSupplyReset) && $past(waitMode) |-> wakeRequest)
      else $error("no wake on reset in wait");

   // stop-mode trip bypasses the filter
   stop_trip_a: assert property (@(posedge mclk) disable iff (rst) // [R15]
      stopTrip && !lowSupplyReset |=> lowSupplyReset)
      else $error("stop trip did not reset");

   // idle in stop without the stop option
   stop_idle_a: assert property (@(posedge mclk) disable iff (rst) // [R16]
      stopMode && !q.opts.stopEn && !lowSupplyReset |=> !lowSupplyReset)
      else $error("reset in stop with stop option clear");

   // flag never sets before the short end of its window
   flag_early_a: assert property (@(posedge mclk) disable iff (rst) // [R7]
      $rose(lowSupplyFlag) |-> lowTicks >= FLAG_MIN_OSC)
      else $error("status flag set too early");

   // a low stretch past the long end of the window shows the flag
   flag_late_a: assert property (@(posedge mclk) disable iff (rst) // [R7] [R8]
      lowTicks > FLAG_MAX_OSC |-> lowSupplyFlag)
      else $error("status flag missing after long low stretch");

   // wake request is a single-cycle pulse
   wake_single_a: assert property (@(posedge mclk) disable iff (rst) // [R14]
      wakeRequest |=> !wakeRequest)
      else $error("wake request longer than one cycle");

   // straps caught on the first edge after reset
   opts_latch_a: assert property (@(posedge mclk) disable iff (rst) // [R1]
      !q.optsValid |=> q.optsValid)
      else $error("options not caught after reset");

   // reset entry always leaves its event bit set
   event_set_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
      $rose(lowSupplyReset) |-> q.events[EVT_RESET_BIT])
      else $error("reset event bit not set");

   // flag frozen in stop without the stop option
   stop_flag_a: assert property (@(posedge mclk) disable iff (rst) // [R16]
      stopMode && !q.opts.stopEn && !timerClear |=> $stable(lowSupplyFlag))
      else $error("flag moved in stop with stop option clear");

   // other system resets clear the flag
   sys_clear_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
      sysResetIn |=> !lowSupplyFlag)
      else $error("flag not cleared by system reset");

   // oscillator tick lasts one cycle
   tick_single_a: assert property (@(posedge mclk) disable iff (rst) // [R17]
      xtalTick |=> !xtalTick)
      else $error("oscillator tick longer than one cycle");

   // stop trip also wakes the processor
   stop_wake_a: assert property (@(posedge mclk) disable iff (rst) // [R15]
      stopTrip && !lowSupplyReset |=> wakeRequest)
      else $error("no wake on stop trip");
endmodule

// ==== dv/lvm_supply_model.sv ====
// far-side model: supply comparator pair and crystal oscillator
// assumes level 0 is below falling, 1 between levels, 2 above rising
`timescale 1ns/1ps
module lvm_supply_model (
   // requested supply level
   input wire logic [1:0] level,
   // comparator outputs and oscillator pin
   output logic supplyBelowFall,
   output logic supplyAboveRise,
   output logic crystalOscillatorClock
);
   // comparators, never both high at once
   assign supplyBelowFall = (level == 2'h0);
   assign supplyAboveRise = (level == 2'h2);
   // free-running crystal, phase unrelated to mclk
   initial begin
      crystalOscillatorClock = 1'b0;
      #3;
      forever #35 crystalOscillatorClock = ~crystalOscillatorClock;
   end
endmodule

// ==== dv/test_low_voltage_reset_monitor.sv ====
// self-checking bench for the low-voltage reset monitor
// assumes lvm_pkg and the supply model are compiled first
`timescale 1ns/1ps
module test_low_voltage_reset_monitor;
   import lvm_pkg::*;
   logic mclk, rst, pwr, rstEn, stopEn, waitMode, stopMode, sysResetIn;
   logic [1:0] level;
   lvm_bus_t regBus;
   logic [DATA_W-1:0] regRdata;
   logic lowSupplyReset, resetPinOut, resetPinOeN, wakeRequest, lowSupplyFlag;
   logic below, above, osc, expRst, expStop, expFlag;
   int n_mismatch, comparisons, cycles, wakes, w0, glitch;

   lvm_supply_model supply (.level(level), .supplyBelowFall(below),
      .supplyAboveRise(above), .crystalOscillatorClock(osc));
   lvm_monitor uut (.mclk(mclk), .rst(rst), .monitorPowerOption(pwr),
      .lowSupplyResetEnable(rstEn), .stopModeMonitorEnable(stopEn),
      .supplyBelowFall(below), .supplyAboveRise(above),
      .crystalOscillatorClock(osc), .waitMode(waitMode), .stopMode(stopMode),
      .sysResetIn(sysResetIn), .regBus(regBus), .regRdata(regRdata),
      .lowSupplyReset(lowSupplyReset), .resetPinOut(resetPinOut),
      .resetPinOeN(resetPinOeN), .wakeRequest(wakeRequest),
      .lowSupplyFlag(lowSupplyFlag));

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      check({7'h00, got}, {7'h00, exp});
   endtask

   // timeout, wake pulse count
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (wakeRequest === 1'b1)
         wakes <= wakes + 1;
      if (cycles == 12000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   // reset pin follows the forced reset every cycle
   always @(negedge mclk) begin
      if (!rst)
         check({6'h00, resetPinOut, resetPinOeN}, {7'h00, ~lowSupplyReset});
   end

   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      regBus.wr <= 1'b0;
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      regBus.rd <= 1'b0;
      @(negedge mclk);
      check(regRdata, exp);
   endtask

   // set supply level, hold it n more edges, settle
   task automatic go(input logic [1:0] lv, input int n);
      @(posedge mclk);
      level <= lv;
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   // one strap setting: reset, filter, flag, release, stop mode
   task automatic run(input logic [2:0] k);
      @(posedge mclk);
      rst <= 1'b1;
      {stopEn, rstEn, pwr} <= k;
      level <= 2'h1;
      waitMode <= 1'b1;
      stopMode <= 1'b0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      expRst = k[0] & k[1];
      expFlag = k[0] & ~k[1];
      expStop = &k;
      rdchk(CONFIG_OFS, {5'h00, k});
      wr(CONFIG_OFS, 8'hFF);
      rdchk(CONFIG_OFS, {5'h00, k});
      wr(8'h03, 8'h5A);
      rdchk(8'h03, 8'h00);
      rdchk(STATUS_OFS, 8'h00);
      glitch = 1 + $urandom % 8;
      go(2'h0, glitch - 1);
      go(2'h1, 15);
      chk1(lowSupplyReset, 1'b0);
      w0 = wakes;
      go(2'h0, 10);
      chk1(lowSupplyReset, 1'b0);
      go(2'h0, 0);
      chk1(lowSupplyReset, expRst);
      go(2'h0, 130);
      chk1(lowSupplyFlag, 1'b0);
      go(2'h0, 300);
      chk1(lowSupplyFlag, expFlag);
      check(8'(wakes - w0), {7'h00, expRst});
      rdchk(CONFIG_OFS, {expRst, 4'h0, k});
      go(2'h1, 40);
      chk1(lowSupplyReset, expRst);
      chk1(lowSupplyFlag, expFlag);
      @(posedge mclk);
      sysResetIn <= 1'b1;
      @(posedge mclk);
      sysResetIn <= 1'b0;
      go(2'h1, 2);
      chk1(lowSupplyFlag, 1'b0);
      go(2'h2, 0);
      go(2'h1, 5);
      chk1(lowSupplyReset, 1'b0);
      rdchk(EVENT_OFS, {7'h00, expRst});
      wr(EVENT_OFS, 8'h03);
      rdchk(EVENT_OFS, 8'h00);
      @(posedge mclk);
      waitMode <= 1'b0;
      stopMode <= 1'b1;
      go(2'h0, 11);
      go(2'h1, 4);
      chk1(lowSupplyReset, expStop);
      rdchk(EVENT_OFS, {6'h00, expStop, expStop});
      @(posedge mclk);
      stopMode <= 1'b0;
      go(2'h2, 0);
      go(2'h1, 5);
      chk1(lowSupplyReset, 1'b0);
      $display("strap setting %0d done", k);
   endtask

   // main sequence over every strap combination
   initial begin
      rst = 1'b1;
      {pwr, rstEn, stopEn, waitMode, stopMode, sysResetIn} = 6'h00;
      level = 2'h1;
      regBus = '0;
      n_mismatch = 0;
      comparisons = 0;
      cycles = 0;
      wakes = 0;
      void'($urandom(80));
      for (int i = 0; i < 8; i++) begin
         run(3'(i));
      end
      print_verdict();
   end
endmodule
